// ---- src/twb_consts.vh ----
// Constants and the behaviour summary of the timer waveform block.
// What this block does
// - Channel works in waveform mode while its waveform select bit is set.
// - Makes one or two PWM signals, or one-shot or repeating pulses.
// - Line A always driven; line B driven in waveform mode unless chosen as event source.
// - Compare A, B and C are all compared against the counter.
// - Compare C match stops and/or disables counter clock per mode bits.
// - With trigger enable set, compare C match triggers and resets counter.
// - External event on chosen source and edge; edge none means no event.
// - Event source 0 selects line B; line B then stops being driven.
// - External event triggers only when its trigger enable bit is set.
// - Block sync, software trigger and compare C also trigger the channel.
// - Line B output control applies only while line B is an output.
// - Trigger, event and compare C act on both lines; A and B on their own.
// - Each event sets, clears or toggles its line per its action field.
// - Coinciding events: software, then external, then C, then A or B.
// - Compare A, B, C flags set on match, held until status is read.
// - Overflow flag set when counter passes its maximum, held until read.
// - External trigger flag set on detection, held until status is read.
// - Channels at 0x00, 0x40, 0x80; block control 0xc0, block mode 0xc4.
// - Compare A and B writable only in waveform mode.
// - Block control bit 0 written 1 triggers all channels in one cycle.
// - Clock line 0 selects pin 0, nothing, channel 1 A, channel 2 A.
// - Lines 1 and 2 select their pin, nothing, or the other channels' A.
// - 16-bit up-counter counts on valid clock edges and wraps to zero.
// - A trigger zeroes the counter on the next edge and starts the clock if it is enabled.
`ifndef TWB_CONSTS_VH
`define TWB_CONSTS_VH
`define TWB_CH_STRIDE 8'h40
`define TWB_OFF_CCR 6'h00
`define TWB_OFF_CMR 6'h04
`define TWB_OFF_CV 6'h10
`define TWB_OFF_CMP_A 6'h14
`define TWB_OFF_CMP_B 6'h18
`define TWB_OFF_CMP_C 6'h1c
`define TWB_OFF_SR 6'h20
`define TWB_OFF_IER 6'h24
`define TWB_OFF_IDR 6'h28
`define TWB_OFF_IMR 6'h2c
`define TWB_OFF_BCR 8'hc0
`define TWB_OFF_BMR 8'hc4
`define TWB_CMR_RESET 32'h00000000
`define TWB_BMR_RESET 6'h00
`define TWB_CCR_CLKEN 0
`define TWB_CCR_CLKDIS 1
`define TWB_CCR_SWTRG 2
`define TWB_CMR_CLKS_LSB 0
`define TWB_CMR_CLKI 3
`define TWB_CMR_C_STOP 6
`define TWB_CMR_C_DIS 7
`define TWB_CMR_EDG_LSB 8
`define TWB_CMR_SRC_LSB 10
`define TWB_CMR_EV_TRIG 12
`define TWB_CMR_C_TRIG 14
`define TWB_CMR_WAVE 15
`define TWB_CMR_A_MATCH_A 16
`define TWB_CMR_A_MATCH_C 18
`define TWB_CMR_A_EVENT 20
`define TWB_CMR_A_SOFT 22
`define TWB_CMR_B_MATCH_B 24
`define TWB_CMR_B_MATCH_C 26
`define TWB_CMR_B_EVENT 28
`define TWB_CMR_B_SOFT 30
`define TWB_SR_OVF 0
`define TWB_SR_MATCH_A 2
`define TWB_SR_MATCH_B 3
`define TWB_SR_MATCH_C 4
`define TWB_SR_EXT_TRIG 7
`define TWB_SR_CLKSTA 16
`define TWB_SR_MTIOA 17
`define TWB_SR_MTIOB 18
`define TWB_FLAG_MASK 8'h9d
`define TWB_ACT_NONE 2'b00
`define TWB_ACT_SET 2'b01
`define TWB_ACT_CLEAR 2'b10
`define TWB_ACT_TOGGLE 2'b11
`define TWB_EDG_NONE 2'b00
`define TWB_EDG_RISE 2'b01
`define TWB_EDG_FALL 2'b10
`define TWB_EDG_BOTH 2'b11
`endif

// ---- src/twb_channel.v ----
// One timer channel in waveform mode with its registers and output lines.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "twb_consts.vh"
module twb_channel #(
  parameter CW = 16
)(
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire wr,
  input wire rd,
  input wire [5:0] addr,
  input wire [31:0] wdata,
  input wire sync,
  input wire [2:0] xc,
  input wire line_b_in,
  output reg [31:0] rdata,
  output reg io_line_a,
  output reg io_line_b,
  output wire io_line_b_oen,
  output wire irq
);
  reg [31:0] mode;
  reg [CW-1:0] count;
  reg [CW-1:0] compare_reg_a;
  reg [CW-1:0] compare_reg_b;
  reg [CW-1:0] compare_reg_c;
  reg [7:0] flags;
  reg [7:0] mask;
  reg clk_en;
  reg clk_run;
  reg clk_prev;
  reg ev_prev;
  reg trig_pend;
  wire wave = mode[`TWB_CMR_WAVE];
  wire [1:0] edg = mode[`TWB_CMR_EDG_LSB+1:`TWB_CMR_EDG_LSB];
  wire [1:0] src = mode[`TWB_CMR_SRC_LSB+1:`TWB_CMR_SRC_LSB];
  wire b_is_input = (src == 2'b00);
  wire [2:0] clks = mode[`TWB_CMR_CLKS_LSB+2:`TWB_CMR_CLKS_LSB];
  reg clk_sel;
  reg ev_sig;
  always @*
  begin
    case (clks)
      3'd5: clk_sel = xc[0];
      3'd6: clk_sel = xc[1];
      3'd7: clk_sel = xc[2];
      default: clk_sel = 1'b1;
    endcase
    case (src)
      2'd1: ev_sig = xc[0];
      2'd2: ev_sig = xc[1];
      2'd3: ev_sig = xc[2];
      default: ev_sig = line_b_in;
    endcase
  end
  wire clk_lvl = clk_sel ^ mode[`TWB_CMR_CLKI];
  wire internal = (clks < 3'd5);
  wire tick = clk_en && clk_run && (internal || (clk_lvl && !clk_prev));
  wire ev_det = wave && ((edg == `TWB_EDG_RISE && ev_sig && !ev_prev) ||
    (edg == `TWB_EDG_FALL && !ev_sig && ev_prev) ||
    (edg == `TWB_EDG_BOTH && ev_sig != ev_prev));
  wire sw_trig = (wr && addr == `TWB_OFF_CCR && wdata[`TWB_CCR_SWTRG])
    || sync;
  wire ext_trig = ev_det && mode[`TWB_CMR_EV_TRIG];
  wire match_a = wave && tick && count == compare_reg_a;
  wire match_b = wave && tick && count == compare_reg_b;
  wire match_c = wave && tick && count == compare_reg_c;
  wire c_trig = match_c && mode[`TWB_CMR_C_TRIG];
  wire trig_now = sw_trig || ext_trig || c_trig;
  wire ovf = tick && !trig_pend && !trig_now && (&count);
  function [1:0] twb_pick;
    input sw;
    input ev;
    input mc;
    input mx;
    input [7:0] act;
    begin
      if (sw)
        twb_pick = act[7:6];
      else if (ev)
        twb_pick = act[5:4];
      else if (mc)
        twb_pick = act[3:2];
      else if (mx)
        twb_pick = act[1:0];
      else
        twb_pick = `TWB_ACT_NONE;
    end
  endfunction
  function twb_apply;
    input cur;
    input [1:0] act;
    begin
      case (act)
        `TWB_ACT_SET: twb_apply = 1'b1;
        `TWB_ACT_CLEAR: twb_apply = 1'b0;
        `TWB_ACT_TOGGLE: twb_apply = ~cur;
        default: twb_apply = cur;
      endcase
    end
  endfunction
  wire [1:0] act_a = twb_pick(sw_trig && wave, ev_det, match_c, match_a,
    mode[`TWB_CMR_A_MATCH_A+7:`TWB_CMR_A_MATCH_A]);
  wire [1:0] act_b = twb_pick(sw_trig && wave, ev_det, match_c, match_b,
    mode[`TWB_CMR_B_MATCH_B+7:`TWB_CMR_B_MATCH_B]);
  assign io_line_b_oen = !(wave && !b_is_input);
  wire sr_read = rd && addr == `TWB_OFF_SR;
  wire [7:0] ev_set = {ext_trig, 2'b00, match_c, match_b, match_a, 1'b0, ovf};
  assign irq = |(flags & mask);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode <= `TWB_CMR_RESET;
      count <= {CW{1'b0}};
      compare_reg_a <= {CW{1'b0}};
      compare_reg_b <= {CW{1'b0}};
      compare_reg_c <= {CW{1'b0}};
      flags <= 8'h00;
      mask <= 8'h00;
      clk_en <= 1'b0;
      clk_run <= 1'b0;
      clk_prev <= 1'b0;
      ev_prev <= 1'b0;
      trig_pend <= 1'b0;
      io_line_a <= 1'b0;
      io_line_b <= 1'b0;
    end
    else if (ce)
    begin
      clk_prev <= clk_lvl;
      ev_prev <= ev_sig;
      // Set wins over the read clear.
      flags <= ((sr_read ? 8'h00 : flags) | ev_set) &
        `TWB_FLAG_MASK;
      if (wr && addr == `TWB_OFF_CMR)
        mode <= wdata;
      if (wr && addr == `TWB_OFF_CMP_A && wave)
        compare_reg_a <= wdata[CW-1:0];
      if (wr && addr == `TWB_OFF_CMP_B && wave)
        compare_reg_b <= wdata[CW-1:0];
      if (wr && addr == `TWB_OFF_CMP_C)
        compare_reg_c <= wdata[CW-1:0];
      if (wr && addr == `TWB_OFF_IER)
        mask <= mask | (wdata[7:0] & `TWB_FLAG_MASK);
      else if (wr && addr == `TWB_OFF_IDR)
        mask <= mask & ~wdata[7:0];
      if (wr && addr == `TWB_OFF_CCR && wdata[`TWB_CCR_CLKDIS])
        clk_en <= 1'b0;
      else if (wr && addr == `TWB_OFF_CCR && wdata[`TWB_CCR_CLKEN])
        clk_en <= 1'b1;
      else if (match_c && mode[`TWB_CMR_C_DIS])
        clk_en <= 1'b0;
      if (trig_now)
      begin
        trig_pend <= 1'b1;
        clk_run <= clk_en || (wr && addr == `TWB_OFF_CCR &&
          wdata[`TWB_CCR_CLKEN] && !wdata[`TWB_CCR_CLKDIS]);
      end
      else if (match_c && mode[`TWB_CMR_C_STOP])
        clk_run <= 1'b0;
      if (wr && addr == `TWB_OFF_CV)
        count <= wdata[CW-1:0];
      else if (tick)
      begin
        // A trigger on a counting edge zeroes the count on that same edge.
        trig_pend <= 1'b0;
        count <= (trig_pend || trig_now) ? {CW{1'b0}} :
          count + 1'b1;
      end
      if (wave)
      begin
        io_line_a <= twb_apply(io_line_a, act_a);
        if (!b_is_input)
          io_line_b <= twb_apply(io_line_b, act_b);
      end
    end
  end
  always @*
  begin
    case (addr)
      `TWB_OFF_CMR: rdata = mode;
      `TWB_OFF_CV: rdata = {{(32-CW){1'b0}}, count};
      `TWB_OFF_CMP_A: rdata = {{(32-CW){1'b0}}, compare_reg_a};
      `TWB_OFF_CMP_B: rdata = {{(32-CW){1'b0}}, compare_reg_b};
      `TWB_OFF_CMP_C: rdata = {{(32-CW){1'b0}}, compare_reg_c};
      `TWB_OFF_SR: rdata = {13'h0000, io_line_b, io_line_a, clk_en,
        8'h00, flags};
      `TWB_OFF_IMR: rdata = {24'h000000, mask};
      default: rdata = 32'h00000000;
    endcase
  end
endmodule

// ---- src/twb_top.v ----
// Three-channel timer block with APB slave and external clock routing.
`timescale 1ns/1ps
`include "twb_consts.vh"
module twb_top #(
  parameter CW = 16
)(
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [2:0] clock_pin,
  input wire [2:0] io_line_b_in,
  output wire [2:0] io_line_a,
  output wire [2:0] io_line_b,
  output wire [2:0] io_line_b_oen,
  output wire [2:0] irq
);
  reg [2:0] s1;
  reg [2:0] s2;
  reg [2:0] s3;
  reg [2:0] b1;
  reg [2:0] b2;
  reg [2:0] b3;
  reg [2:0] pin_f;
  reg [2:0] b_f;
  reg [5:0] bmr;
  reg [31:0] prd_next;
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  wire bcr_sync = wr && paddr == `TWB_OFF_BCR && pwdata[0];
  wire [95:0] ch_rdata;
  wire [2:0] xc;
  function twb_route;
    input [1:0] sel;
    input pin;
    input oa;
    input ob;
    begin
      case (sel)
        2'b00: twb_route = pin;
        2'b10: twb_route = oa;
        2'b11: twb_route = ob;
        default: twb_route = 1'b0;
      endcase
    end
  endfunction
  assign xc[0] = twb_route(bmr[1:0], pin_f[0], io_line_a[1],
    io_line_a[2]);
  assign xc[1] = twb_route(bmr[3:2], pin_f[1], io_line_a[0],
    io_line_a[2]);
  assign xc[2] = twb_route(bmr[5:4], pin_f[2], io_line_a[0],
    io_line_a[1]);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1 <= 3'b000;
      s2 <= 3'b000;
      s3 <= 3'b000;
      b1 <= 3'b000;
      b2 <= 3'b000;
      b3 <= 3'b000;
      pin_f <= 3'b000;
      b_f <= 3'b000;
      bmr <= `TWB_BMR_RESET;
    end
    else if (clk_en)
    begin
      s1 <= clock_pin;
      s2 <= s1;
      s3 <= s2;
      b1 <= io_line_b_in;
      b2 <= b1;
      b3 <= b2;
      pin_f <= (s2 & s3) | (pin_f & (s2 | s3));
      b_f <= (b2 & b3) | (b_f & (b2 | b3));
      if (wr && paddr == `TWB_OFF_BMR)
        bmr <= pwdata[5:0];
    end
  end
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1)
    begin : g_ch
      twb_channel #(.CW(CW)) twb_channel_inst (
        .pclk(pclk),
        .presetn(presetn),
        .ce(clk_en),
        .wr(wr && paddr[7:6] == i),
        .rd(rd && paddr[7:6] == i && clk_en),
        .addr(paddr[5:0]),
        .wdata(pwdata),
        .sync(bcr_sync),
        .xc(xc),
        .line_b_in(b_f[i]),
        .rdata(ch_rdata[32*i+31:32*i]),
        .io_line_a(io_line_a[i]),
        .io_line_b(io_line_b[i]),
        .io_line_b_oen(io_line_b_oen[i]),
        .irq(irq[i])
      );
    end
  endgenerate
  always @*
  begin
    case (paddr[7:6])
      2'd0: prd_next = ch_rdata[31:0];
      2'd1: prd_next = ch_rdata[63:32];
      2'd2: prd_next = ch_rdata[95:64];
      default: prd_next = (paddr == `TWB_OFF_BMR) ? {26'h0, bmr} : 32'h0;
    endcase
    prdata = prd_next;
  end
endmodule

// ---- testbench/twb_monitor.sv ----
// Port checker of the timer waveform block.
`timescale 1ns/1ps
module twb_monitor (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire [2:0] io_line_a,
  input wire [2:0] io_line_b_oen,
  input wire [2:0] irq
);
  wire wr = psel && penable && pwrite && clk_en;
  wire rd = psel && penable && !pwrite;
  wire [5:0] off = paddr[5:0];
  wire [1:0] ch = paddr[7:6];
  reg [31:0] mode [0:2];
  reg [15:0] cmpa;
  reg [7:0] mask;
  reg [5:0] bmr;
  reg [2:0] drv_q;
  wire [2:0] drv;
  // Line B is driven in waveform mode unless it is the event source.
  assign drv = {mode[2][15] && mode[2][11:10] != 2'h0,
    mode[1][15] && mode[1][11:10] != 2'h0,
    mode[0][15] && mode[0][11:10] != 2'h0};
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mode[0] <= 32'h0;
      mode[1] <= 32'h0;
      mode[2] <= 32'h0;
      cmpa <= 16'h0;
      mask <= 8'h0;
      bmr <= 6'h0;
      drv_q <= 3'h0;
    end
    else
    begin
      drv_q <= drv;
      if (wr && ch != 2'h3 && off == 6'h04)
        mode[ch] <= pwdata;
      if (wr && paddr == 8'h14 && mode[0][15])
        cmpa <= pwdata[15:0];
      if (wr && paddr == 8'h24)
        mask <= mask | (pwdata[7:0] & 8'h9d);
      if (wr && paddr == 8'h28)
        mask <= mask & ~pwdata[7:0];
      if (wr && paddr == 8'hc4)
        bmr <= pwdata[5:0];
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_line_b_drive: assert property (drv_q == drv |->
    io_line_b_oen == ~drv)
    else $error("line B enable wrong");
  a_cmpa_guard: assert property (rd && paddr == 8'h14 |->
    prdata[15:0] == cmpa)
    else $error("compare A value wrong");
  a_mask_read: assert property (rd && paddr == 8'h2c |->
    prdata[7:0] == mask)
    else $error("mask value wrong");
  a_irq_mask: assert property (irq[0] |-> mask != 8'h0)
    else $error("irq without mask");
  a_hole_zero: assert property (rd && (off == 6'h08 || off == 6'h0c ||
    off > 6'h2c) |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_route_read: assert property (rd && paddr == 8'hc4 |->
    prdata == {26'h0, bmr})
    else $error("block mode value wrong");
  a_mode_read: assert property (rd && ch != 2'h3 && off == 6'h04 |->
    prdata == mode[ch])
    else $error("mode value wrong");
  a_sync_set: assert property (wr && paddr == 8'hc0 && pwdata[0] &&
    mode[1][15] && mode[1][23:22] == 2'b01 |-> ##[1:3] io_line_a[1])
    else $error("sync did not set line A");
  a_line_a_idle: assert property (!mode[0][15] && !$past(mode[0][15]) |->
    $stable(io_line_a[0]))
    else $error("line A moved outside waveform mode");
  cover property (rd && paddr == 8'h20);
  cover property (irq[0]);
  cover property ($rose(io_line_a[0]));
endmodule

// ---- testbench/twb_partner.sv ----
// Model of the clock pins and line B sources outside the block.
`timescale 1ns/1ps
module twb_partner (
  input wire pclk,
  input wire [2:0] io_line_b,
  input wire [2:0] io_line_b_oen,
  output reg [2:0] clock_pin,
  output wire [2:0] io_line_b_in
);
  reg [2:0] ext_b;
  // Released line B carries the outside source, else the block's level.
  assign io_line_b_in = (io_line_b_oen & ext_b) |
    (~io_line_b_oen & io_line_b);
  initial
  begin
    clock_pin = 3'h0;
    ext_b = 3'h0;
  end
  // Each level lasts several system clocks so it is seen.
  task pulse(input integer n, input integer b);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1)
      begin
        repeat (4) @(posedge pclk);
        if (b != 0)
          ext_b <= 3'h7;
        else
          clock_pin[0] <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_b <= 3'h0;
        clock_pin[0] <= 1'b0;
      end
    end
  endtask
endmodule

// ---- testbench/test_timer_waveform_block.sv ----
// Self-checking testbench of the timer waveform block.
`timescale 1ns/1ps
module test_timer_waveform_block;
  reg pclk;
  reg presetn;
  reg psel;
  reg penable;
  reg pwrite;
  reg [7:0] paddr;
  reg [31:0] pwdata;
  reg [31:0] q;
  reg ce;
  wire [31:0] prdata;
  wire pready;
  wire [2:0] cpin;
  wire [2:0] b_in;
  wire [2:0] io_line_a;
  wire [2:0] io_line_b;
  wire [2:0] io_line_b_oen;
  wire [2:0] irq;
  integer num_errors;
  integer total_checks;
  integer cyc;
  integer n;
  integer h;
  twb_top #(.CW(16)) twb_top_inst (.pclk(pclk), .presetn(presetn),
    .clk_en(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(), .clock_pin(cpin), .io_line_b_in(b_in),
    .io_line_a(io_line_a), .io_line_b(io_line_b),
    .io_line_b_oen(io_line_b_oen), .irq(irq));
  twb_partner twb_partner_inst (.pclk(pclk), .io_line_b(io_line_b),
    .io_line_b_oen(io_line_b_oen), .clock_pin(cpin), .io_line_b_in(b_in));
  task complete_run;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e)
      begin
        num_errors = num_errors + 1;
        $display("[ERR] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task bus(input [7:0] a, input w, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rdc(input string nm, input [7:0] a, input [31:0] e);
    begin
      bus(a, 1'b0, 32'h0);
      chk(nm, e, q);
    end
  endtask
  task gap(input integer i, input v, output integer c);
    begin
      c = 0;
      while (io_line_a[i] === v)
      begin
        @(negedge pclk);
        c = c + 1;
      end
      @(posedge pclk);
    end
  endtask
  task t_reset;
    begin
      rdc("mode", 8'h04, 32'h0);
      rdc("count", 8'h10, 32'h0);
      rdc("mask", 8'h2c, 32'h0);
      rdc("route", 8'hc4, 32'h0);
      rdc("hole", 8'h08, 32'h0);
      bus(8'h14, 1'b1, 32'h5);
      rdc("cmp_a_ro", 8'h14, 32'h0);
      chk("oen", 32'h7, {29'h0, io_line_b_oen});
      $display("test reset done");
    end
  endtask
  task t_pwm;
    begin
      bus(8'h04, 1'b1, 32'h0006c000);
      bus(8'h1c, 1'b1, 32'd40);
      bus(8'h14, 1'b1, 32'd10);
      rdc("cmp_a_rw", 8'h14, 32'd10);
      bus(8'h00, 1'b1, 32'h5);
      gap(0, 1'b0, n);
      gap(0, 1'b1, h);
      gap(0, 1'b0, n);
      chk("high", 32'd11, h);
      chk("period", 32'd41, h + n);
      bus(8'h24, 1'b1, 32'h10);
      chk("irq_on", 32'h1, {31'h0, irq[0]});
      bus(8'h28, 1'b1, 32'h10);
      chk("irq_off", 32'h0, {31'h0, irq[0]});
      bus(8'h00, 1'b1, 32'h2);
      bus(8'h20, 1'b0, 32'h0);
      chk("flags", 32'h1c, q & 32'h9d);
      rdc("flags_clr", 8'h20,
        {13'h0, io_line_b[0], io_line_a[0], 17'h0});
      $display("test pwm done");
    end
  endtask
  task t_sync;
    begin
      bus(8'h44, 1'b1, 32'h00408000);
      bus(8'h84, 1'b1, 32'h00408000);
      bus(8'h40, 1'b1, 32'h1);
      bus(8'h80, 1'b1, 32'h1);
      bus(8'hc0, 1'b1, 32'h0);
      chk("sync0", 32'h0, {30'h0, io_line_a[2:1]});
      bus(8'hc0, 1'b1, 32'h1);
      repeat (3) @(posedge pclk);
      chk("sync1", 32'h3, {30'h0, io_line_a[2:1]});
      bus(8'h44, 1'b1, 32'h00808000);
      bus(8'h40, 1'b1, 32'h4);
      repeat (3) @(posedge pclk);
      chk("swtrig", 32'h2, {30'h0, io_line_a[2:1]});
      $display("test sync done");
    end
  endtask
  task t_event;
    begin
      bus(8'h84, 1'b1, 32'h00309100);
      repeat (2) @(posedge pclk);
      chk("b_free", 32'h1, {31'h0, io_line_b_oen[2]});
      bus(8'ha0, 1'b0, 32'h0);
      twb_partner_inst.pulse(1, 1);
      repeat (6) @(posedge pclk);
      chk("ev_tog", 32'h0, {31'h0, io_line_a[2]});
      bus(8'ha0, 1'b0, 32'h0);
      chk("ev_flag", 32'h80, q & 32'h80);
      bus(8'h84, 1'b1, 32'h00309500);
      repeat (2) @(posedge pclk);
      chk("b_drv", 32'h0, {31'h0, io_line_b_oen[2]});
      $display("test event done");
    end
  endtask
  task t_route;
    begin
      bus(8'h04, 1'b1, 32'h00008005);
      bus(8'h00, 1'b1, 32'h5);
      twb_partner_inst.pulse(3, 0);
      repeat (6) @(posedge pclk);
      rdc("pin_cnt", 8'h10, 32'd2);
      bus(8'hc4, 1'b1, 32'h1);
      twb_partner_inst.pulse(2, 0);
      repeat (6) @(posedge pclk);
      rdc("none_cnt", 8'h10, 32'd2);
      bus(8'h04, 1'b1, 32'h00008000);
      bus(8'h00, 1'b1, 32'h5);
      ce <= 1'b0;
      bus(8'h10, 1'b0, 32'h0);
      n = q;
      repeat (4) @(posedge pclk);
      rdc("freeze", 8'h10, n);
      ce <= 1'b1;
      repeat (2) @(posedge pclk);
      bus(8'h10, 1'b0, 32'h0);
      chk("thaw", 32'h1, {31'h0, q != n});
      $display("test route done");
    end
  endtask
  always @(posedge pclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      num_errors = num_errors + 1;
      complete_run;
    end
  end
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    num_errors = 0;
    total_checks = 0;
    cyc = 0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_pwm;
    t_sync;
    t_event;
    t_route;
    complete_run;
  end
endmodule
bind twb_top twb_monitor twb_monitor_inst (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .io_line_a(io_line_a),
  .io_line_b_oen(io_line_b_oen), .irq(irq));
